/* verilog/flash_led_pkg.sv */
`default_nettype none
package flash_led_pkg;
   localparam int unsigned MCLK_HZ = 200_000_000;
   localparam int unsigned SAFETY_TIMEOUT_S = 1;
   localparam int unsigned SAFETY_TIMEOUT_CYCLES = MCLK_HZ * SAFETY_TIMEOUT_S;
   localparam int unsigned I2C_RATE_HZ = 400_000;
   localparam int unsigned I2C_QUARTER_CYCLES = MCLK_HZ / (I2C_RATE_HZ * 4);
   localparam logic [6:0] SLAVE_ADDR = 7'h37;
   localparam logic [7:0] CTRL_REG_ADDR = 8'h02;
   localparam logic [7:0] CTRL_RESET = 8'h10;
   localparam logic [7:0] CODE_MASK = 8'hcf;
   localparam int TIMEOUT_EN_BIT = 4;
   localparam logic [7:0] HOST_CMD_OFS = 8'h00;
   localparam logic [7:0] HOST_PIN_OFS = 8'h04;
   localparam logic [7:0] HOST_STAT_OFS = 8'h08;
   localparam logic [7:0] HOST_IRQ_STAT_OFS = 8'h0c;
   localparam logic [7:0] HOST_IRQ_MASK_OFS = 8'h10;
   localparam int CMD_GO_BIT = 8;
   localparam int PIN_EN_BIT = 0;
   localparam int PIN_TRIG_BIT = 1;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_NACK_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      SLV_IDLE = 4'h0,
      SLV_ADDR = 4'h1,
      SLV_ACKA = 4'h2,
      SLV_REG = 4'h3,
      SLV_ACKR = 4'h4,
      SLV_DATA = 4'h5,
      SLV_ACKD = 4'h6,
      SLV_RDAT = 4'h7,
      SLV_RACK = 4'h8
   } slv_phase_t;

   typedef enum logic [1:0] {
      MST_IDLE = 2'h0,
      MST_START = 2'h1,
      MST_BITS = 2'h2,
      MST_STOP = 2'h3
   } mst_phase_t;
endpackage : flash_led_pkg
`default_nettype wire

/* verilog/flash_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface flash_link_if;
   logic hostSclOut;
   logic hostSclOe;
   logic hostSdaOut;
   logic hostSdaOe;
   logic devSdaOut;
   logic devSdaOe;
   logic scl;
   logic sda;
   logic flash_trigger_pin;
   logic chipEnable;

   // Open-drain wires with pull-ups
   assign scl = hostSclOe ? hostSclOut : 1'b1;
   assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

   modport host (
      output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe, flash_trigger_pin, chipEnable,
      input scl, sda
   );
   modport dev (
      output devSdaOut, devSdaOe,
      input scl, sda, flash_trigger_pin, chipEnable
   );
endinterface : flash_link_if
`default_nettype wire

/* verilog/flash_host_ctrl.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl #(
   parameter int unsigned QUARTER_CYCLES = flash_led_pkg::I2C_QUARTER_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Interrupt
   output logic irq,
   // Link
   flash_link_if.host link
);
   import flash_led_pkg::*;

   if (QUARTER_CYCLES < 2 || QUARTER_CYCLES > 65535) begin : gBadDiv
      $error("QUARTER_CYCLES out of range");
   end

   typedef struct packed {
      logic [1:0] sda;
      logic awHave;
      logic [7:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic en;
      logic trig;
      logic [7:0] data;
      logic busy;
      logic nack;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      mst_phase_t phase;
      logic [1:0] q;
      logic [15:0] div;
      logic [1:0] byteIdx;
      logic [3:0] bitIdx;
      logic sclOe;
      logic sdaOe;
   } host_state_t;

   host_state_t s;
   host_state_t n;

   function automatic logic [7:0] frameByte(input logic [1:0] idx, input logic [7:0] d);
      frameByte = (idx == 2'd0) ? {SLAVE_ADDR, 1'b0} : (idx == 2'd1) ? CTRL_REG_ADDR : d;
   endfunction : frameByte

   always_comb begin
      logic tick;
      logic doWr;
      logic [1:0] setIrq;
      logic [1:0] clrIrq;
      logic [7:0] cur;
      tick = 1'b0;
      doWr = 1'b0;
      setIrq = 2'b00;
      clrIrq = 2'b00;
      cur = 8'h00;
      n = s;
      n.sda = {s.sda[0], link.sda};
      // ************
      // Register bus
      // ************
      if (awvalid && awready) begin
         n.awHave = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         n.wHave = 1'b1;
         n.wData = wdata;
         n.wStrb = wstrb;
      end
      if (bvalid && bready) begin
         n.bValid = 1'b0;
      end
      doWr = n.awHave && n.wHave && !s.bValid;
      if (doWr) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bValid = 1'b1;
         n.bResp = RESP_OKAY;
         case (n.awAddr)
            HOST_CMD_OFS: begin
               // A command while busy is dropped
               if (n.wStrb[1] && n.wData[CMD_GO_BIT] && !s.busy) begin
                  n.data = n.wData[7:0];
                  n.busy = 1'b1;
                  n.nack = 1'b0;
                  n.phase = MST_START;
                  n.q = 2'd0;
                  n.div = 16'h0000;
               end
            end
            HOST_PIN_OFS: begin
               if (n.wStrb[0]) begin
                  n.en = n.wData[PIN_EN_BIT];
                  n.trig = n.wData[PIN_TRIG_BIT];
               end
            end
            HOST_STAT_OFS: begin
            end
            HOST_IRQ_STAT_OFS: begin
            end
            HOST_IRQ_MASK_OFS: begin
               if (n.wStrb[0]) begin
                  n.irqMask = n.wData[1:0];
               end
            end
            default: begin
               n.bResp = RESP_SLVERR;
            end
         endcase
      end
      if (rvalid && rready) begin
         n.rValid = 1'b0;
      end
      if (arvalid && arready) begin
         n.rValid = 1'b1;
         n.rResp = RESP_OKAY;
         case (araddr)
            HOST_CMD_OFS: n.rData = {24'h000000, s.data};
            HOST_PIN_OFS: n.rData = {30'h00000000, s.trig, s.en};
            HOST_STAT_OFS: n.rData = {30'h00000000, s.nack, s.busy};
            HOST_IRQ_STAT_OFS: begin
               n.rData = {30'h00000000, s.irqStat};
               clrIrq = 2'b11;
            end
            HOST_IRQ_MASK_OFS: n.rData = {30'h00000000, s.irqMask};
            default: begin
               n.rData = 32'h00000000;
               n.rResp = RESP_SLVERR;
            end
         endcase
      end
      // ************
      // Serial master
      // ************
      if (s.phase != MST_IDLE) begin
         tick = (s.div == 16'(QUARTER_CYCLES - 1));
         n.div = tick ? 16'h0000 : s.div + 16'h0001;
      end
      cur = frameByte(s.byteIdx, s.data);
      if (tick) begin
         n.q = s.q + 2'd1;
         case (s.phase)
            MST_START: begin
               case (s.q)
                  2'd0: begin
                     n.sclOe = 1'b0;
                     n.sdaOe = 1'b0;
                  end
                  2'd1: n.sdaOe = 1'b1;
                  2'd2: n.sclOe = 1'b1;
                  default: begin
                     n.phase = MST_BITS;
                     n.byteIdx = 2'd0;
                     n.bitIdx = 4'd0;
                  end
               endcase
            end
            MST_BITS: begin
               case (s.q)
                  2'd0: n.sdaOe = (s.bitIdx == 4'd8) ? 1'b0 : ~cur[3'd7 - s.bitIdx[2:0]];
                  2'd1: n.sclOe = 1'b0;
                  2'd2: begin
                     if (s.bitIdx == 4'd8 && s.sda[1]) begin
                        n.nack = 1'b1;
                     end
                  end
                  default: begin
                     n.sclOe = 1'b1;
                     if (s.bitIdx == 4'd8) begin
                        n.bitIdx = 4'd0;
                        n.byteIdx = s.byteIdx + 2'd1;
                        if (s.byteIdx == 2'd2 || s.nack) begin
                           n.phase = MST_STOP;
                        end
                     end else begin
                        n.bitIdx = s.bitIdx + 4'd1;
                     end
                  end
               endcase
            end
            MST_STOP: begin
               case (s.q)
                  2'd0: n.sdaOe = 1'b1;
                  2'd1: n.sclOe = 1'b0;
                  2'd2: n.sdaOe = 1'b0;
                  default: begin
                     n.phase = MST_IDLE;
                     n.busy = 1'b0;
                     setIrq[IRQ_DONE_BIT] = 1'b1;
                     setIrq[IRQ_NACK_BIT] = s.nack;
                  end
               endcase
            end
            default: begin
               n.phase = MST_IDLE;
            end
         endcase
      end
      // Set beats clear when both land together
      n.irqStat = (s.irqStat & ~clrIrq) | setIrq;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign awready = !s.awHave && !s.bValid;
   assign wready = !s.wHave && !s.bValid;
   assign bvalid = s.bValid;
   assign bresp = s.bResp;
   assign arready = !s.rValid;
   assign rvalid = s.rValid;
   assign rdata = s.rData;
   assign rresp = s.rResp;
   assign irq = |(s.irqStat & s.irqMask);
   assign link.hostSclOut = 1'b0;
   assign link.hostSclOe = s.sclOe;
   assign link.hostSdaOut = 1'b0;
   assign link.hostSdaOe = s.sdaOe;
   assign link.flash_trigger_pin = s.trig;
   assign link.chipEnable = s.en;
endmodule : flash_host_ctrl
`default_nettype wire

/* verilog/flash_led_control_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_led_control_timer #(
   parameter int unsigned TIMEOUT_CYCLES = flash_led_pkg::SAFETY_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Link
   flash_link_if.dev link,
   // Thermal indication
   input wire logic overTemp,
   // Sink and status
   output logic led_sink_output,
   output logic [7:0] ledCurrentCode,
   output logic safety_timeout_enable,
   output logic timedOut,
   output logic sleepMode,
   output logic chargePumpOn
);
   import flash_led_pkg::*;

   localparam int TW = 28;

   if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << TW)) begin : gBadTimeout
      $error("TIMEOUT_CYCLES out of range");
   end

   typedef struct packed {
      logic [2:0] scl;
      logic [2:0] sda;
      logic [1:0] trig;
      logic [1:0] en;
      logic [1:0] ot;
      slv_phase_t phase;
      logic [3:0] bits;
      logic [7:0] shift;
      logic rw;
      logic [7:0] regPtr;
      logic sdaOe;
      logic [7:0] ctrl;
      logic [TW-1:0] timer;
      logic timedOut;
      logic sink;
   } dev_state_t;

   dev_state_t s;
   dev_state_t n;

   function automatic logic [7:0] readValue(input logic [7:0] ptr, input logic [7:0] ctrl);
      readValue = (ptr == CTRL_REG_ADDR) ? ctrl : 8'h00;
   endfunction : readValue

   always_comb begin
      logic sclRise;
      logic sclFall;
      logic start;
      logic stop;
      logic wrCtrl;
      logic [7:0] wrVal;
      logic countOn;
      sclRise = 1'b0;
      sclFall = 1'b0;
      start = 1'b0;
      stop = 1'b0;
      wrCtrl = 1'b0;
      wrVal = 8'h00;
      countOn = 1'b0;
      n = s;
      // *************
      // Synchronisers
      // *************
      // Stage 2 and the history bit only are read below
      n.scl = {s.scl[1:0], link.scl};
      n.sda = {s.sda[1:0], link.sda};
      n.trig = {s.trig[0], link.flash_trigger_pin};
      n.en = {s.en[0], link.chipEnable};
      n.ot = {s.ot[0], overTemp};
      sclRise = s.scl[1] && !s.scl[2];
      sclFall = !s.scl[1] && s.scl[2];
      start = s.scl[1] && s.scl[2] && s.sda[2] && !s.sda[1];
      stop = s.scl[1] && s.scl[2] && !s.sda[2] && s.sda[1];
      // ************
      // Serial slave
      // ************
      // Serial side never sleeps: it runs off mclk regardless of sink
      if (start) begin
         n.phase = SLV_ADDR;
         n.bits = 4'd0;
         n.sdaOe = 1'b0;
      end else if (stop) begin
         n.phase = SLV_IDLE;
         n.sdaOe = 1'b0;
      end else if (sclRise) begin
         case (s.phase)
            SLV_ADDR, SLV_REG, SLV_DATA: begin
               n.shift = {s.shift[6:0], s.sda[1]};
               n.bits = s.bits + 4'd1;
            end
            SLV_RDAT: begin
               n.shift = {s.shift[6:0], 1'b0};
               n.bits = s.bits + 4'd1;
            end
            SLV_RACK: begin
               // Single byte per read; no auto increment
               n.phase = SLV_IDLE;
            end
            default: begin
            end
         endcase
      end else if (sclFall) begin
         case (s.phase)
            SLV_ADDR: begin
               if (s.bits == 4'd8) begin
                  if (s.shift[7:1] == SLAVE_ADDR) begin
                     n.sdaOe = 1'b1;
                     n.rw = s.shift[0];
                     n.phase = SLV_ACKA;
                  end else begin
                     n.phase = SLV_IDLE;
                  end
               end
            end
            SLV_ACKA: begin
               n.bits = 4'd0;
               if (s.rw) begin
                  n.shift = readValue(s.regPtr, s.ctrl);
                  n.sdaOe = ~n.shift[7];
                  n.phase = SLV_RDAT;
               end else begin
                  n.sdaOe = 1'b0;
                  n.phase = SLV_REG;
               end
            end
            SLV_REG: begin
               if (s.bits == 4'd8) begin
                  n.regPtr = s.shift;
                  n.sdaOe = 1'b1;
                  n.phase = SLV_ACKR;
               end
            end
            SLV_ACKR, SLV_ACKD: begin
               n.sdaOe = 1'b0;
               n.bits = 4'd0;
               n.phase = SLV_DATA;
            end
            SLV_DATA: begin
               if (s.bits == 4'd8) begin
                  wrCtrl = (s.regPtr == CTRL_REG_ADDR);
                  wrVal = s.shift;
                  n.sdaOe = 1'b1;
                  n.phase = SLV_ACKD;
               end
            end
            SLV_RDAT: begin
               if (s.bits == 4'd8) begin
                  n.sdaOe = 1'b0;
                  n.phase = SLV_RACK;
               end else begin
                  n.sdaOe = ~s.shift[7];
               end
            end
            default: begin
            end
         endcase
      end
      // ****************
      // Control register
      // ****************
      // All eight bits stored; bit five kept as written
      if (wrCtrl) begin
         n.ctrl = wrVal;
         // Writing the off code drops the time-out latch
         if ((wrVal & CODE_MASK) == 8'h00) begin
            n.timedOut = 1'b0;
         end
      end
      // ************
      // Safety timer
      // ************
      if (!s.trig[1]) begin
         n.timedOut = 1'b0;
      end
      countOn = s.sink && s.ctrl[TIMEOUT_EN_BIT];
      if (countOn) begin
         if (s.timer == TW'(TIMEOUT_CYCLES - 1)) begin
            n.timedOut = 1'b1;
            n.timer = '0;
         end else begin
            n.timer = s.timer + TW'(1);
         end
      end else begin
         // Continuous on-time only; any gap restarts the count
         n.timer = '0;
      end
      // Over-temperature forces the sink off but leaves ctrl alone
      n.sink = s.trig[1] && ((n.ctrl & CODE_MASK) != 8'h00)
               && !n.timedOut && !s.ot[1];
      // **************
      // Chip shutdown
      // **************
      if (!s.en[1]) begin
         n.phase = SLV_IDLE;
         n.bits = 4'd0;
         n.shift = 8'h00;
         n.rw = 1'b0;
         n.regPtr = 8'h00;
         n.sdaOe = 1'b0;
         n.ctrl = CTRL_RESET;
         n.timer = '0;
         n.timedOut = 1'b0;
         n.sink = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.ctrl <= CTRL_RESET;
      end else begin
         s <= n;
      end
   end

   assign led_sink_output = s.sink;
   assign ledCurrentCode = s.ctrl & CODE_MASK;
   assign safety_timeout_enable = s.ctrl[TIMEOUT_EN_BIT];
   assign timedOut = s.timedOut;
   assign sleepMode = !s.sink;
   assign chargePumpOn = s.sink;
   assign link.devSdaOut = 1'b0;
   assign link.devSdaOe = s.sdaOe;
endmodule : flash_led_control_timer
`default_nettype wire

/* verification/flash_led_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_led_chk #(
   parameter int unsigned TIMEOUT_CYCLES = flash_led_pkg::SAFETY_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Link pins
   input wire logic scl,
   input wire logic devSdaOe,
   input wire logic flash_trigger_pin,
   input wire logic chipEnable,
   // Device side
   input wire logic overTemp,
   input wire logic led_sink_output,
   input wire logic [7:0] ledCurrentCode,
   input wire logic safety_timeout_enable,
   input wire logic timedOut,
   input wire logic sleepMode,
   input wire logic chargePumpOn
);
   logic [31:0] runCnt_q;
   logic [31:0] runCnt_d;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   // Armed sink-on run length; restarts whenever the sink drops
   always_comb begin
      runCnt_d = (led_sink_output && safety_timeout_enable) ? runCnt_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         runCnt_q <= 32'h0;
      end else begin
         runCnt_q <= runCnt_d;
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   a_disabled_default: assert property ((!chipEnable) [*5] |-> !led_sink_output && ledCurrentCode == 8'h00 && safety_timeout_enable)
      else $error("device not at defaults while disabled");
   a_trigger_low_off: assert property ((!flash_trigger_pin) [*5] |-> !led_sink_output)
      else $error("sink on with trigger low");
   a_hot_off: assert property (overTemp [*5] |-> !led_sink_output)
      else $error("sink on during over-temperature");
   a_sleep_tracks_sink: assert property (sleepMode == !led_sink_output && chargePumpOn == led_sink_output)
      else $error("sleep or pump disagrees with sink");
   a_late_timeout: assert property (runCnt_q <= TIMEOUT_CYCLES + 1)
      else $error("armed sink stayed on past the timeout");
   a_early_timeout: assert property ($rose(timedOut) |-> runCnt_q >= TIMEOUT_CYCLES - 1 && $past(safety_timeout_enable))
      else $error("timeout without a full armed run");
   a_latch_holds_off: assert property (timedOut && $past(timedOut) |-> !led_sink_output)
      else $error("sink on while timed out");
   a_rearm_trigger: assert property ((!flash_trigger_pin) [*5] |-> !timedOut)
      else $error("timeout latch kept with trigger low");
   a_off_code_dark: assert property (led_sink_output |-> ledCurrentCode != 8'h00)
      else $error("sink on with the off code");
   a_sda_on_low_clock: assert property ($changed(devSdaOe) |-> !scl)
      else $error("device changed data line while clock high");

   c_timeout: cover property ($rose(timedOut));
   c_hot_cut: cover property (overTemp && $fell(led_sink_output));
   c_ack: cover property ($rose(devSdaOe));
endmodule : flash_led_chk
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import flash_led_pkg::*;
   localparam int unsigned TO = 100;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic overTemp = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic led_sink_output, safety_timeout_enable, timedOut, sleepMode, chargePumpOn;
   logic [7:0] ledCurrentCode;
   int errors = 0;
   int n_checks = 0;
   // Every flash and spotlight code, D5 kept zero, D4 set only for flash
   logic [7:0] codes [37] = '{8'h5b, 8'h5d, 8'hd5, 8'h1e, 8'h9a, 8'h13, 8'hd9, 8'h15, 8'hdd, 8'h17, 8'hdf,
      8'h19, 8'h1b, 8'h1d, 8'h95, 8'h1f, 8'h97, 8'h99, 8'h9b, 8'h9d, 8'h9f, 8'h00, 8'h42, 8'hc2, 8'h02, 8'h46,
      8'h04, 8'hc6, 8'h4a, 8'h06, 8'h4e, 8'hca, 8'h08, 8'h45, 8'h47, 8'hce, 8'h49};

   flash_link_if link ();
   flash_host_ctrl #(.QUARTER_CYCLES(4)) flash_host_ctrl_i (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .link(link));
   flash_led_control_timer #(.TIMEOUT_CYCLES(TO)) flash_led_control_timer_i (.mclk(mclk), .rst_b(rst_b),
      .link(link), .overTemp(overTemp), .led_sink_output(led_sink_output), .ledCurrentCode(ledCurrentCode),
      .safety_timeout_enable(safety_timeout_enable), .timedOut(timedOut), .sleepMode(sleepMode),
      .chargePumpOn(chargePumpOn));
   flash_led_chk #(.TIMEOUT_CYCLES(TO)) flash_led_chk_i (.mclk(mclk), .rst_b(rst_b), .scl(link.scl),
      .devSdaOe(link.devSdaOe), .flash_trigger_pin(link.flash_trigger_pin), .chipEnable(link.chipEnable),
      .overTemp(overTemp), .led_sink_output(led_sink_output), .ledCurrentCode(ledCurrentCode),
      .safety_timeout_enable(safety_timeout_enable), .timedOut(timedOut), .sleepMode(sleepMode),
      .chargePumpOn(chargePumpOn));

   always #2.5 mclk = ~mclk;

   // ************************************************
   // Bus and compare tasks
   // ************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awDone;
      logic wDone;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awDone = 1'b0;
      wDone = 1'b0;
      while (!(awDone && wDone)) begin
         @(posedge mclk);
         if (awvalid && awready) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge mclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   // One serial write of the control register; irq seen before the irq status read clears it
   task automatic send(input logic [7:0] code, output logic [31:0] irqs, output logic il);
      logic [31:0] st;
      logic [1:0] r;
      axi_wr(HOST_CMD_OFS, {23'h0, 1'b1, code}, r);
      st = 32'h1;
      while (st[0] !== 1'b0) axi_rd(HOST_STAT_OFS, st, r);
      il = irq;
      axi_rd(HOST_IRQ_STAT_OFS, irqs, r);
   endtask : send

   task automatic pins(input logic [1:0] p);
      logic [1:0] r;
      axi_wr(HOST_PIN_OFS, {30'h0, p}, r);
      repeat (8) @(posedge mclk);
   endtask : pins

   task automatic dev_chk(input logic s, input logic [7:0] c, input logic e, input logic t);
      check("sink", 32'(s), 32'(led_sink_output));
      check("sleep", 32'(!s), 32'(sleepMode));
      check("pump", 32'(s), 32'(chargePumpOn));
      check("code", 32'(c), 32'(ledCurrentCode));
      check("timeout enable", 32'(e), 32'(safety_timeout_enable));
      check("timed out", 32'(t), 32'(timedOut));
   endtask : dev_chk

   task automatic wrap_up();
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // ************************************************
   // Tests
   // ************************************************
   initial begin
      logic [31:0] v;
      logic [1:0] r;
      logic il;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      dev_chk(1'b0, 8'h00, 1'b1, 1'b0);
      check("irq idle", 32'h0, 32'(irq));
      axi_rd(8'h20, v, r);
      check("unmapped read", 32'(RESP_SLVERR), 32'(r));
      axi_wr(8'h24, 32'h1, r);
      check("unmapped write", 32'(RESP_SLVERR), 32'(r));
      axi_wr(HOST_IRQ_MASK_OFS, 32'h3, r);
      axi_rd(HOST_IRQ_MASK_OFS, v, r);
      check("mask readback", 32'h3, v);
      // Disabled device must not answer its address
      send(8'h5b, v, il);
      check("nack while disabled", 32'h1, 32'(v[1]));
      check("irq on nack", 32'h1, 32'(il));
      check("irq cleared", 32'h0, 32'(irq));
      dev_chk(1'b0, 8'h00, 1'b1, 1'b0);
      pins(2'b01);
      send(8'h5b, v, il);
      check("irq status", 32'h1, v & 32'h3);
      check("irq on done", 32'h1, 32'(il));
      axi_rd(HOST_CMD_OFS, v, r);
      check("cmd readback", 32'h5b, v);
      dev_chk(1'b0, 8'h4b, 1'b1, 1'b0);
      pins(2'b11);
      dev_chk(1'b1, 8'h4b, 1'b1, 1'b0);
      repeat (TO + 10) @(posedge mclk);
      dev_chk(1'b0, 8'h4b, 1'b1, 1'b1);
      pins(2'b01);
      dev_chk(1'b0, 8'h4b, 1'b1, 1'b0);
      pins(2'b11);
      dev_chk(1'b1, 8'h4b, 1'b1, 1'b0);
      repeat (TO + 10) @(posedge mclk);
      send(8'h00, v, il);
      dev_chk(1'b0, 8'h00, 1'b0, 1'b0);
      send(8'h5b, v, il);
      dev_chk(1'b1, 8'h4b, 1'b1, 1'b0);
      // Code with D4 clear stays on past twice the timeout; trigger low re-arms first
      pins(2'b01);
      send(8'h49, v, il);
      pins(2'b11);
      repeat (2 * TO) @(posedge mclk);
      dev_chk(1'b1, 8'h49, 1'b0, 1'b0);
      overTemp <= 1'b1;
      repeat (8) @(posedge mclk);
      dev_chk(1'b0, 8'h49, 1'b0, 1'b0);
      overTemp <= 1'b0;
      repeat (8) @(posedge mclk);
      dev_chk(1'b1, 8'h49, 1'b0, 1'b0);
      pins(2'b01);
      axi_wr(HOST_IRQ_MASK_OFS, 32'h0, r);
      foreach (codes[i]) begin
         send(codes[i], v, il);
         check("code table", 32'(codes[i] & CODE_MASK), 32'(ledCurrentCode));
         check("enable bit", 32'(codes[i][4]), 32'(safety_timeout_enable));
         check("masked irq", 32'h0, 32'(il));
         check("sticky done", 32'h1, 32'(v[0]));
      end
      pins(2'b10);
      dev_chk(1'b0, 8'h00, 1'b1, 1'b0);
      pins(2'b11);
      dev_chk(1'b0, 8'h00, 1'b1, 1'b0);
      wrap_up();
   end

   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      $display("Error watchdog expected done seen hang");
      wrap_up();
   end
endmodule : tb
`default_nettype wire
